// ===== core/tig_irq_gate.sv
// Interrupt enable gate with enable, set, clear and status registers.
// Assumes AHB-Lite slave use with hready looped from o_hreadyout, events on i_clk.
//
// Operation
// - An enable bit at 1 lets its condition interrupt; at 0 suppresses it.
// - Interrupt n needs bit n at 1 in both enable word and set register.
// - Writing 1 to clear register bit n stalls interrupt n, enable unchanged.
// - Enable layout: time matches 23..16, ring writes 15..8, then 6, 4..0.
// - Bits 31..24 and 7 read zero; all fields reset to zero.
// - Enable bit n gates the status flag at the same position n.
// - A set-register bit is ignored while its enable bit is zero.
// - Set and clear operations never change the stored enable word; clear also keeps the set mask.
`timescale 1ns/1ps
module tig_irq_gate
	import tig_pkg::*;
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// AHB-Lite slave
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic [31:0] o_hrdata,
	output logic o_hreadyout,
	output logic o_hresp,
	// Event flags from the stream logic
	input wire logic [31:0] i_events,
	// Interrupt to host
	output logic o_irq
);

	tig_state_e state;
	tig_state_e next_state;
	tig_req_s req;
	tig_req_s next_req;
	tig_regs_s regs;
	tig_regs_s next_regs;
	logic [31:0] next_hrdata;
	logic next_irq;
	logic accept;
	logic [31:0] wdata;
	logic [31:0] armed;
	tig_sel_e wsel;

	function automatic tig_sel_e reg_sel(input logic [TIG_ADDR_W-1:0] addr);
		tig_sel_e sel;
		case (addr)
			TIG_OFS_ENABLE: sel = TIG_SEL_ENABLE;
			TIG_OFS_SET: sel = TIG_SEL_SET;
			TIG_OFS_CLEAR: sel = TIG_SEL_CLEAR;
			TIG_OFS_STATUS: sel = TIG_SEL_STATUS;
			TIG_OFS_STATUS_CLR: sel = TIG_SEL_STATUS_CLR;
			default: sel = TIG_SEL_NONE;
		endcase
		return sel;
	endfunction

	// Address phase taken on any valid transfer; single wait state on reads
	assign accept = i_hsel && i_htrans[1] && i_hready;
	assign o_hreadyout = (state != TIG_ST_RD_WAIT);
	assign o_hresp = TIG_HRESP_OKAY[0];
	assign wdata = i_hwdata & TIG_WR_MASK;
	assign wsel = reg_sel(req.addr);

	// Bits armed for the host: set mask counts only under enable, minus stalls
	assign armed = regs.enable & regs.set_mask & ~regs.stall;

	always_comb
	begin
		next_state = TIG_ST_IDLE;
		next_req = req;
		if (accept)
		begin
			next_req.addr = i_haddr[TIG_ADDR_W-1:0];
			next_req.write = i_hwrite;
			next_state = i_hwrite ? TIG_ST_WRITE : TIG_ST_RD_WAIT;
		end
		else if (state == TIG_ST_RD_WAIT)
		begin
			next_state = TIG_ST_RD_DONE;
		end
	end

	always_comb
	begin
		next_hrdata = o_hrdata;
		if (state == TIG_ST_RD_WAIT)
		begin
			case (wsel)
				TIG_SEL_ENABLE: next_hrdata = regs.enable;
				TIG_SEL_SET: next_hrdata = regs.set_mask;
				TIG_SEL_CLEAR: next_hrdata = regs.stall;
				TIG_SEL_STATUS: next_hrdata = regs.status;
				default: next_hrdata = TIG_ZERO;
			endcase
		end
	end

	always_comb
	begin
		next_regs = regs;
		if (state == TIG_ST_WRITE)
		begin
			case (wsel)
				TIG_SEL_ENABLE: next_regs.enable = wdata;
				TIG_SEL_SET:
				begin
					next_regs.set_mask = wdata;
					next_regs.stall = regs.stall & ~wdata;
				end
				TIG_SEL_CLEAR: next_regs.stall = regs.stall | wdata;
				TIG_SEL_STATUS_CLR: next_regs.status = regs.status & ~wdata;
				default: next_regs = regs;
			endcase
		end
		// New events win over a clear in the same cycle
		next_regs.status = next_regs.status | (i_events & TIG_WR_MASK);
		next_irq = |(regs.status & armed);
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			state <= TIG_ST_IDLE;
			req <= '0;
			regs <= '0;
			o_hrdata <= TIG_RESET_VAL;
			o_irq <= 1'b0;
		end
		else
		begin
			state <= next_state;
			req <= next_req;
			regs <= next_regs;
			o_hrdata <= next_hrdata;
			o_irq <= next_irq;
		end
	end

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_rst);

	sequence wr_enable_s;
		state == TIG_ST_WRITE && wsel == TIG_SEL_ENABLE;
	endsequence

	sequence wr_clear_s;
		state == TIG_ST_WRITE && wsel == TIG_SEL_CLEAR;
	endsequence

	sequence wr_set_s;
		state == TIG_ST_WRITE && wsel == TIG_SEL_SET;
	endsequence

	sequence armed_event_s;
		((i_events & TIG_WR_MASK & armed) != TIG_ZERO) && state != TIG_ST_WRITE
		##1 state != TIG_ST_WRITE;
	endsequence

	a_enable_write_mask: assert property (
		wr_enable_s |=> regs.enable == ($past(i_hwdata) & TIG_WR_MASK))
		else $error("enable word not stored from write data");

	a_reserved_read_zero: assert property (
		state == TIG_ST_RD_DONE |-> o_hrdata[31:24] == 8'h00 && !o_hrdata[7]
			|| $past(wsel) == TIG_SEL_STATUS)
		else $error("reserved bits read nonzero");

	a_reset_all_off: assert property (
		$past(i_rst) |-> regs.enable == TIG_ZERO && regs.set_mask == TIG_ZERO && !o_irq)
		else $error("state not cleared by reset");

	a_clear_keeps_masks: assert property (
		wr_clear_s |=> regs.enable == $past(regs.enable)
			&& regs.set_mask == $past(regs.set_mask))
		else $error("clear write altered stored masks");

	a_clear_stalls_irq: assert property (
		(wr_clear_s and ((i_hwdata & TIG_WR_MASK) == TIG_WR_MASK))
		##1 state != TIG_ST_WRITE |=> !o_irq)
		else $error("irq not stalled by clear write");

	a_disabled_no_irq: assert property (
		(regs.enable & regs.set_mask) == TIG_ZERO |=> !o_irq)
		else $error("irq raised with no bit enabled in both masks");

	a_armed_event_irq: assert property (
		armed_event_s |=> o_irq)
		else $error("armed event did not raise irq in two cycles");

	a_status_set_wins: assert property (
		state == TIG_ST_WRITE && wsel == TIG_SEL_STATUS_CLR
		|=> (regs.status & $past(i_events) & TIG_WR_MASK) == ($past(i_events) & TIG_WR_MASK))
		else $error("event lost under status clear");

	a_read_one_wait: assert property (
		state == TIG_ST_RD_WAIT |-> !o_hreadyout ##1 o_hreadyout)
		else $error("read wait state not exactly one cycle");

	a_write_no_wait: assert property (
		state == TIG_ST_WRITE |-> o_hreadyout)
		else $error("write data phase inserted a wait state");

	a_clear_sets_stall: assert property (
		wr_clear_s |=> (regs.stall & $past(i_hwdata) & TIG_WR_MASK)
			== ($past(i_hwdata) & TIG_WR_MASK))
		else $error("clear write did not stall its bits");

	a_set_keeps_enable: assert property (
		wr_set_s |=> regs.enable == $past(regs.enable))
		else $error("set write altered the enable word");

	a_irq_needs_armed: assert property (
		o_irq |-> ($past(regs.status) & $past(armed)) != TIG_ZERO)
		else $error("irq raised with no armed status bit");

endmodule

// ===== core/tig_pkg.sv
// Package for the interrupt enable gate: register map, field layout, types.
// Assumes a 32-bit AHB-Lite register bus and one peripheral clock.
package tig_pkg;

	// Register byte offsets within the block window
	localparam int TIG_ADDR_W = 8;
	localparam logic [TIG_ADDR_W-1:0] TIG_OFS_ENABLE = 8'h00;
	localparam logic [TIG_ADDR_W-1:0] TIG_OFS_SET = 8'h04;
	localparam logic [TIG_ADDR_W-1:0] TIG_OFS_CLEAR = 8'h08;
	localparam logic [TIG_ADDR_W-1:0] TIG_OFS_STATUS = 8'h0c;
	localparam logic [TIG_ADDR_W-1:0] TIG_OFS_STATUS_CLR = 8'h10;

	// Field positions of the enable word
	localparam int TIG_TIME_MATCH_LSB = 16;
	localparam int TIG_RING_WRITE_LSB = 8;
	localparam int TIG_RX_PKT_ERR_BIT = 6;
	localparam int TIG_RING_READ_BIT = 4;
	localparam int TIG_PROG_MAP_BIT = 3;
	localparam int TIG_PROG_ASSOC_BIT = 2;
	localparam int TIG_PIC_GROUP_BIT = 1;
	localparam int TIG_BOUNDARY_BIT = 0;

	// Writable bits: 23..8 and 6..0; 31..24 and 7 read as zero
	localparam logic [31:0] TIG_WR_MASK = 32'h00ff_ff7f;
	localparam logic [31:0] TIG_RESET_VAL = 32'h0000_0000;
	localparam logic [31:0] TIG_ZERO = 32'h0000_0000;
	localparam logic [31:0] TIG_ONES = 32'hffff_ffff;

	// AHB-Lite encodings
	localparam logic [1:0] TIG_HRESP_OKAY = 2'h0;

	// Register select decode
	typedef enum logic [2:0]
	{
		TIG_SEL_NONE = 3'h0,
		TIG_SEL_ENABLE = 3'h1,
		TIG_SEL_SET = 3'h2,
		TIG_SEL_CLEAR = 3'h3,
		TIG_SEL_STATUS = 3'h4,
		TIG_SEL_STATUS_CLR = 3'h5
	} tig_sel_e;

	// Bus transfer state
	typedef enum logic [3:0]
	{
		TIG_ST_IDLE = 4'b0001,
		TIG_ST_WRITE = 4'b0010,
		TIG_ST_RD_WAIT = 4'b0100,
		TIG_ST_RD_DONE = 4'b1000
	} tig_state_e;

	// Captured address phase
	typedef struct packed
	{
		logic [TIG_ADDR_W-1:0] addr;
		logic write;
	} tig_req_s;

	// Stored mask and status state
	typedef struct packed
	{
		logic [31:0] enable;
		logic [31:0] set_mask;
		logic [31:0] stall;
		logic [31:0] status;
	} tig_regs_s;

endpackage

// ===== verification/tig_irq_gate_tb.sv
// Testbench for the interrupt enable gate: register access, masks, interrupt.
// Assumes one AHB-Lite master with hready looped back from the slave.
`timescale 1ns/1ps
module tb
	import tig_pkg::*;
;
	logic i_clk, i_rst, i_hsel, i_hwrite, o_hreadyout, o_hresp, o_irq;
	logic [31:0] i_haddr, i_hwdata, i_events, o_hrdata;
	logic [1:0] i_htrans;
	logic [2:0] i_hsize;
	int mismatches, comparisons;

	tig_irq_gate u_tig_irq_gate(.i_clk(i_clk), .i_rst(i_rst), .i_hsel(i_hsel),
		.i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize),
		.i_hwdata(i_hwdata), .i_hready(o_hreadyout), .o_hrdata(o_hrdata),
		.o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .i_events(i_events), .o_irq(o_irq));

	task automatic results();
		if (mismatches == 0 && comparisons > 0)
		begin
			$display("SIMULATION PASSED");
		end
		else
		begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// Bounded wait for an edge with hready high
	task automatic wait_rdy();
		int n;
		n = 0;
		do
		begin
			@(posedge i_clk);
			n++;
		end
		while (o_hreadyout !== 1'b1 && n < 16);
		if (o_hreadyout !== 1'b1)
		begin
			mismatches++;
			results();
		end
	endtask

	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		i_hsel <= 1'b1;
		i_htrans <= 2'h2;
		i_haddr <= {24'h0, a};
		i_hwrite <= wr;
		wait_rdy();
		i_htrans <= 2'h0;
		i_hwdata <= d;
		wait_rdy();
		q = o_hrdata;
		chk({31'h0, o_hresp}, 32'h0);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(q, exp);
	endtask

	task automatic see(input logic e);
		@(posedge i_clk);
		#1;
		chk({31'h0, o_irq}, {31'h0, e});
		@(posedge i_clk);
	endtask

	task automatic pulse(input logic [31:0] v, input logic e);
		i_events <= v;
		@(posedge i_clk);
		i_events <= 32'h0;
		see(e);
	endtask

	task automatic s_reset();
		rd(8'h00, 32'h0);
		rd(8'h04, 32'h0);
		rd(8'h08, 32'h0);
		rd(8'h0c, 32'h0);
		rd(8'h40, 32'h0);
		see(1'b0);
	endtask

	task automatic s_layout();
		wr(8'h00, 32'hffff_ffff);
		rd(8'h00, 32'h00ff_ff7f);
		wr(8'h40, 32'hffff_ffff);
		rd(8'h40, 32'h0);
		wr(8'h00, 32'h0);
		rd(8'h00, 32'h0);
	endtask

	task automatic s_gate();
		wr(8'h04, 32'h0080_0000);
		pulse(32'h0080_0000, 1'b0);
		wr(8'h00, 32'h0080_0000);
		see(1'b1);
		wr(8'h08, 32'h0080_0000);
		see(1'b0);
		rd(8'h08, 32'h0080_0000);
		rd(8'h00, 32'h0080_0000);
		rd(8'h04, 32'h0080_0000);
	endtask

	task automatic s_position();
		wr(8'h10, 32'hffff_ffff);
		wr(8'h00, 32'h0000_0001);
		wr(8'h04, 32'h0000_0001);
		pulse(32'hff00_0080, 1'b0);
		pulse(32'h0000_0002, 1'b0);
		pulse(32'h0000_0001, 1'b1);
		rd(8'h0c, 32'h0000_0003);
		wr(8'h08, 32'hffff_ffff);
		see(1'b0);
		wr(8'h04, 32'h0000_0001);
		see(1'b1);
	endtask

	task automatic s_rerun();
		i_rst <= 1'b1;
		repeat (2) @(posedge i_clk);
		i_rst <= 1'b0;
		chk({31'h0, o_irq}, 32'h0);
		rd(8'h00, 32'h0);
		rd(8'h04, 32'h0);
		rd(8'h08, 32'h0);
		rd(8'h0c, 32'h0);
	endtask

	initial
	begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end

	initial
	begin
		i_rst = 1'b1;
		i_hsel = 1'b0;
		i_htrans = 2'h0;
		i_haddr = 32'h0;
		i_hwrite = 1'b0;
		i_hsize = 3'h2;
		i_hwdata = 32'h0;
		i_events = 32'h0;
		mismatches = 0;
		comparisons = 0;
		repeat (2) @(posedge i_clk);
		i_rst <= 1'b0;
		repeat (2) @(posedge i_clk);
		s_reset();
		s_layout();
		s_gate();
		s_position();
		s_rerun();
		results();
	end
endmodule
